/* File: logic/gxd_pkg.sv */
// Purpose: constants and types for the graphics host address decoder
// Assumes: 20-bit host address, 16-bit host data, AXI4-Lite side registers
// Notes: every address field position and register offset lives here
package gxd_pkg;
    // ====================
    // host address field positions
    localparam int SEL_HI = 19;
    localparam int SEL_LO = 17;
    localparam int FBUPD_BIT = 16;
    localparam int RSEL_HI = 15;
    localparam int RSEL_LO = 14;
    localparam int SLOT_HI = 13;
    localparam int SLOT_LO = 12;
    localparam int AXIS_BIT = 11;
    localparam int COORD_HI = 10;
    localparam int COORD_LO = 1;
    localparam int CMD_HI = 2;
    localparam int CMD_LO = 1;
    // ====================
    // register-select and command codes
    localparam logic [1:0] RSEL_NONE = 2'h0;
    localparam logic [1:0] RSEL_CMD = 2'h1;
    localparam logic [1:0] RSEL_SRC = 2'h2;
    localparam logic [1:0] RSEL_MASK = 2'h3;
    localparam logic [1:0] CMD_FUNC = 2'h0;
    localparam logic [1:0] CMD_WIDTH = 2'h1;
    localparam logic [1:0] CMD_CTRL = 2'h2;
    localparam logic [1:0] CMD_CLRI = 2'h3;
    // control word bits
    localparam int CTRL_IE_BIT = 8;
    localparam int CTRL_VID_BIT = 9;
    // ====================
    // interrupt status bits
    localparam int IRQ_VBLANK = 0;
    localparam int IRQ_ACCESS = 1;
    localparam int IRQ_N = 2;
    // ====================
    // axi register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_CFG = 8'h0c;
    localparam logic [7:0] OFS_FUNC = 8'h10;
    localparam logic [7:0] OFS_WIDTH = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_SRC = 8'h1c;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ====================
    // values after reset
    localparam logic [7:0] RST_FUNC = 8'haa;
    localparam logic [4:0] RST_WIDTH = 5'h10;
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [2:0] RST_BOARD = 3'h0;
    // one decoded host access
    typedef struct packed {
        logic wr;
        logic fb_upd;
        logic [1:0] rsel;
        logic [1:0] slot;
        logic axis;
        logic [9:0] coord;
        logic [1:0] cmd;
    } gxd_acc_t;
endpackage

/* File: logic/gxd_decoder.sv */
// Purpose: host address decoder of a bit-mapped graphics board
// Assumes: host strobes and address arrive asynchronously; frame buffer on ref_clk
// Notes: frame buffer read data is sampled in the same cycle that fb_rd_req is high
//
// Behaviour
// - respond only when board-select bits match
// - bit 16 gates frame-buffer update
// - select 00 loads only a coordinate
// - select 01 loads command register by bits 2:1
// - select 10 loads source register
// - select 11 loads mask, width bits only
// - write takes source or mask from data bus
// - read takes source or mask from frame buffer
// - bits 13:12 pick one of four slots
// - every access updates one coordinate register
// - bit 11 picks x or y axis
// - bits 10:1 carry the coordinate
// - command codes: function, width, control, clear
// - width sets loaded bits and pixels
// - read latch shows previous source value
`timescale 1ns/10ps
module gxd_decoder #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] hb_addr,
    input wire logic [DW-1:0] hb_data_i,
    output logic [DW-1:0] hb_data_o,
    output logic hb_data_oe,
    input wire logic hb_wr_n,
    input wire logic hb_rd_n,
    input wire logic vblank,
    output logic [9:0] fb_x,
    output logic [9:0] fb_y,
    output logic fb_rd_req,
    input wire logic [DW-1:0] fb_rdata,
    output logic fb_wr_req,
    output logic [7:0] fb_func,
    output logic [4:0] fb_width,
    output logic [DW-1:0] fb_src,
    output logic [DW-1:0] fb_mask,
    output logic video_en,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ====================
    // helpers
    // high-justified mask of the top w bits; widths above 16 clamp to 16
    function automatic logic [DW-1:0] wmask(input logic [4:0] w);
        logic [DW-1:0] m;
        m = '0;
        for (int i = 0; i < DW; i++) begin
            if (i < int'(w)) begin
                m[DW-1-i] = 1'b1;
            end
        end
        return m;
    endfunction

    // merge only the masked bits of a new value into an old one
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
            input logic [DW-1:0] new_v, input logic [DW-1:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction

    // ====================
    // reset release
    logic rst_a_q, rst_b_q; // release sync, async assert
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end
    wire rst_s_n = rst_b_q;

    // ====================
    // pin synchronisers
    // the address is sampled with the strobes; the host holds it stable
    // across the strobe, so a plain two-flop stage is enough here
    logic [AW-1:0] addr_a_q, addr_b_q;
    logic [DW-1:0] din_a_q, din_b_q;
    logic wr_a_q, wr_b_q, rd_a_q, rd_b_q, vb_a_q, vb_b_q;
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            addr_a_q <= '0;
            addr_b_q <= '0;
            din_a_q <= '0;
            din_b_q <= '0;
            {wr_a_q, wr_b_q, rd_a_q, rd_b_q} <= 4'hf;
            {vb_a_q, vb_b_q} <= 2'h0;
        end else begin
            addr_a_q <= hb_addr;
            addr_b_q <= addr_a_q;
            din_a_q <= hb_data_i;
            din_b_q <= din_a_q;
            wr_a_q <= hb_wr_n;
            wr_b_q <= wr_a_q;
            rd_a_q <= hb_rd_n;
            rd_b_q <= rd_a_q;
            vb_a_q <= vblank;
            vb_b_q <= vb_a_q;
        end
    end

    // ====================
    // address decode
    logic [2:0] board_q; // board selection, set over axi
    logic act_prev_q; // strobe level one cycle back
    logic vb_prev_q; // vblank level one cycle back
    wire wr_act = !wr_b_q;
    wire rd_act = !rd_b_q;
    wire strobe = wr_act | rd_act;
    wire start = strobe & !act_prev_q; // first cycle of a host strobe
    wire hit = addr_b_q[gxd_pkg::SEL_HI:gxd_pkg::SEL_LO] == board_q;
    wire take = start & hit;
    gxd_pkg::gxd_acc_t acc_d;
    assign acc_d.wr = wr_act;
    assign acc_d.fb_upd = addr_b_q[gxd_pkg::FBUPD_BIT];
    assign acc_d.rsel = addr_b_q[gxd_pkg::RSEL_HI:gxd_pkg::RSEL_LO];
    assign acc_d.slot = addr_b_q[gxd_pkg::SLOT_HI:gxd_pkg::SLOT_LO];
    assign acc_d.axis = addr_b_q[gxd_pkg::AXIS_BIT];
    assign acc_d.coord = addr_b_q[gxd_pkg::COORD_HI:gxd_pkg::COORD_LO];
    assign acc_d.cmd = addr_b_q[gxd_pkg::CMD_HI:gxd_pkg::CMD_LO];
    wire is_cmd = acc_d.rsel == gxd_pkg::RSEL_CMD;
    wire clr_cmd = take & is_cmd & (acc_d.cmd == gxd_pkg::CMD_CLRI);

    // ====================
    // coordinate registers, four x and four y
    logic [9:0] xr_q [4];
    logic [9:0] yr_q [4];
    // the pair the access points at, with the new coordinate folded in
    wire [9:0] x_new = acc_d.axis ? xr_q[acc_d.slot] : acc_d.coord;
    wire [9:0] y_new = acc_d.axis ? acc_d.coord : yr_q[acc_d.slot];
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            for (int i = 0; i < 4; i++) begin
                xr_q[i] <= '0;
                yr_q[i] <= '0;
            end
        end else if (take) begin
            // any register-select code still updates one coordinate
            if (acc_d.axis) begin
                yr_q[acc_d.slot] <= acc_d.coord;
            end else begin
                xr_q[acc_d.slot] <= acc_d.coord;
            end
        end
    end

    // ====================
    // stage one: command loads, frame address, read latch
    gxd_pkg::gxd_acc_t acc_q; // access waiting for stage two
    logic v1_q; // stage two runs next cycle
    logic [DW-1:0] wdat_q; // host data held for stage two
    logic [7:0] func_q;
    logic [4:0] width_q;
    logic [15:0] ctrl_q;
    logic [DW-1:0] src_q, mask_q, dlat_q;
    logic [9:0] fbx_q, fby_q;
    logic fbrd_q, fbwr_q, oe_q;
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            acc_q <= '0;
            v1_q <= 1'b0;
            wdat_q <= '0;
            func_q <= gxd_pkg::RST_FUNC;
            width_q <= gxd_pkg::RST_WIDTH;
            ctrl_q <= gxd_pkg::RST_CTRL;
            dlat_q <= '0;
            fbx_q <= '0;
            fby_q <= '0;
            fbrd_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            v1_q <= take;
            fbrd_q <= take & rd_act; // frame data wanted for a read
            oe_q <= rd_act & hit; // drive the bus while the read lasts
            if (take) begin
                acc_q <= acc_d;
                wdat_q <= din_b_q;
                fbx_q <= x_new;
                fby_q <= y_new;
            end
            if (take & rd_act) begin
                // the latch is one step behind: it gets the older source
                dlat_q <= src_q;
            end
            if (take & wr_act & is_cmd) begin
                case (acc_d.cmd)
                    gxd_pkg::CMD_FUNC: func_q <= din_b_q[7:0];
                    gxd_pkg::CMD_WIDTH: width_q <= din_b_q[4:0];
                    gxd_pkg::CMD_CTRL: ctrl_q <= din_b_q;
                    default: ; // clear handled in the status logic
                endcase
            end
        end
    end

    // ====================
    // stage two: source and mask loads, frame update request
    wire [DW-1:0] ld_val = acc_q.wr ? wdat_q : fb_rdata;
    wire [DW-1:0] wm = wmask(width_q);
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            src_q <= '0;
            mask_q <= '0;
            fbwr_q <= 1'b0;
        end else begin
            // with bit 16 clear the frame buffer is never asked to change
            fbwr_q <= v1_q & acc_q.fb_upd;
            if (v1_q && acc_q.rsel == gxd_pkg::RSEL_SRC) begin
                src_q <= merge(src_q, ld_val, wm);
            end
            if (v1_q && acc_q.rsel == gxd_pkg::RSEL_MASK) begin
                mask_q <= merge(mask_q, ld_val, wm);
            end
        end
    end

    // ====================
    // interrupt status, enable, clear
    logic [gxd_pkg::IRQ_N-1:0] sts_q, en_q;
    logic irq_q;
    logic [gxd_pkg::IRQ_N-1:0] clr_w; // software clear this cycle
    wire vb_rise = vb_b_q & !vb_prev_q;
    wire [gxd_pkg::IRQ_N-1:0] set_w = {take, vb_rise & ctrl_q[gxd_pkg::CTRL_IE_BIT]};
    wire [gxd_pkg::IRQ_N-1:0] clr_all = clr_w | {1'b0, clr_cmd};
    // a set arriving with its clear wins, so no event is lost
    wire [gxd_pkg::IRQ_N-1:0] sts_d = (sts_q & ~clr_all) | set_w;
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            sts_q <= '0;
            irq_q <= 1'b0;
            act_prev_q <= 1'b0;
            vb_prev_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
            irq_q <= |(sts_q & en_q);
            act_prev_q <= strobe;
            vb_prev_q <= vb_b_q;
        end
    end

    // ====================
    // axi4-lite slave
    logic aw_full_q, w_full_q, awrdy_q, wrdy_q, bvalid_q;
    logic arrdy_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    wire aw_hs = s_axi_awvalid & awrdy_q;
    wire w_hs = s_axi_wvalid & wrdy_q;
    wire wr_do = aw_full_q & w_full_q & !bvalid_q;
    wire aw_full_d = (aw_full_q | aw_hs) & !wr_do;
    wire w_full_d = (w_full_q | w_hs) & !wr_do;
    wire wr_b0 = wr_do & wstrb_q[0];
    wire wr_clr = wr_b0 & (awaddr_q == gxd_pkg::OFS_IRQ_CLR);
    wire wr_en = wr_b0 & (awaddr_q == gxd_pkg::OFS_IRQ_EN);
    wire wr_cfg = wr_b0 & (awaddr_q == gxd_pkg::OFS_CFG);
    wire wr_map = (awaddr_q == gxd_pkg::OFS_IRQ_CLR) | (awaddr_q == gxd_pkg::OFS_IRQ_EN)
        | (awaddr_q == gxd_pkg::OFS_CFG);
    assign clr_w = wr_clr ? wdata_q[gxd_pkg::IRQ_N-1:0] : '0;
    wire ar_hs = s_axi_arvalid & arrdy_q;
    wire rd_done = rvalid_q & s_axi_rready;
    logic [31:0] rd_val;
    logic rd_ok;
    // read selection; status is read only, clear reads as zero
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            gxd_pkg::OFS_STATUS: rd_val[gxd_pkg::IRQ_N-1:0] = sts_q;
            gxd_pkg::OFS_IRQ_CLR: rd_val = 32'h0000_0000;
            gxd_pkg::OFS_IRQ_EN: rd_val[gxd_pkg::IRQ_N-1:0] = en_q;
            gxd_pkg::OFS_CFG: rd_val[2:0] = board_q;
            gxd_pkg::OFS_FUNC: rd_val[7:0] = func_q;
            gxd_pkg::OFS_WIDTH: rd_val[4:0] = width_q;
            gxd_pkg::OFS_CTRL: rd_val[15:0] = ctrl_q;
            gxd_pkg::OFS_SRC: rd_val[DW-1:0] = src_q;
            gxd_pkg::OFS_MASK: rd_val[DW-1:0] = mask_q;
            default: rd_ok = 1'b0;
        endcase
    end
    // write side: address and data taken in either order
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awrdy_q <= 1'b0;
            wrdy_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= gxd_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            en_q <= '0;
            board_q <= gxd_pkg::RST_BOARD;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awrdy_q <= !aw_full_d;
            wrdy_q <= !w_full_d;
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_do) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_map ? gxd_pkg::RESP_OKAY : gxd_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (wr_en) begin
                en_q <= wdata_q[gxd_pkg::IRQ_N-1:0];
            end
            if (wr_cfg) begin
                board_q <= wdata_q[2:0];
            end
        end
    end
    // read side: one read at a time, answer one cycle after address
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            arrdy_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= gxd_pkg::RESP_OKAY;
        end else begin
            arrdy_q <= !(ar_hs | (rvalid_q & !rd_done));
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_val;
                rresp_q <= rd_ok ? gxd_pkg::RESP_OKAY : gxd_pkg::RESP_SLVERR;
            end else if (rd_done) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ====================
    // outputs, all from flip-flops
    assign hb_data_o = dlat_q;
    assign hb_data_oe = oe_q;
    assign fb_x = fbx_q;
    assign fb_y = fby_q;
    assign fb_rd_req = fbrd_q;
    assign fb_wr_req = fbwr_q;
    assign fb_func = func_q;
    assign fb_width = width_q;
    assign fb_src = src_q;
    assign fb_mask = mask_q;
    assign video_en = ctrl_q[gxd_pkg::CTRL_VID_BIT];
    assign irq = irq_q;
    assign s_axi_awready = awrdy_q;
    assign s_axi_wready = wrdy_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arrdy_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule

/* File: bench/gxd_props.sv */
// Purpose: port-level checks of the graphics host address decoder
// Assumes: host keeps the address steady from strobe fall to its next access
// Notes: bind statement sits below the module
`timescale 1ns/10ps
module gxd_props #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] hb_addr,
    input wire logic hb_rd_n,
    input wire logic hb_data_oe,
    input wire logic fb_rd_req,
    input wire logic fb_wr_req,
    input wire logic [7:0] fb_func,
    input wire logic [4:0] fb_width,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // ==========================================
    // single clock domain, reset gates every check
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // both write channels taken on one edge
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // ==========================================
    // host side
    AST_WR_NEEDS_UPD: assert property (fb_wr_req |-> hb_addr[gxd_pkg::FBUPD_BIT])
        else $error("frame update without update bit");
    AST_WR_PULSE: assert property (fb_wr_req |=> !fb_wr_req)
        else $error("frame update pulse too long");
    AST_RD_PULSE: assert property (fb_rd_req |=> !fb_rd_req)
        else $error("frame read pulse too long");
    AST_RD_IN_READ: assert property (fb_rd_req |-> !hb_rd_n)
        else $error("frame read outside a host read");
    AST_OE_ON_READ: assert property ($rose(hb_data_oe) |-> !hb_rd_n)
        else $error("data bus driven without read strobe");
    AST_OE_RELEASE: assert property ($rose(hb_rd_n) |-> ##[1:8] !hb_data_oe)
        else $error("data bus not released after read");
    // reset values must be visible as reset lifts
    AST_RST_VALUES: assert property ($rose(rst_n) |->
        fb_func == gxd_pkg::RST_FUNC && fb_width == gxd_pkg::RST_WIDTH)
        else $error("command registers wrong after reset");
    // ==========================================
    // register bus answers come within a bounded time
    AST_B_AFTER_WR: assert property (wr_go |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response missing");
endmodule
bind gxd_decoder gxd_props #(.AW(AW), .DW(DW)) u_props (.*);

/* File: bench/gxd_host_model.sv */
// Purpose: behavioural host processor on the parallel system bus
// Assumes: strobe low six clocks, high at least eight clocks between accesses
// Notes: address held until the next access; data released after writes
`timescale 1ns/10ps
module gxd_host_model (
    input wire logic ref_clk,
    output logic [19:0] hb_addr,
    output logic [15:0] hb_data_i,
    output logic hb_wr_n,
    output logic hb_rd_n
);
    // idle bus at time zero
    initial begin
        hb_addr = 20'h00000;
        hb_data_i = 16'h0000;
        hb_wr_n = 1'b1;
        hb_rd_n = 1'b1;
    end
    // one host cycle; address settles a clock before the strobe
    task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        hb_addr <= a;
        hb_data_i <= wr ? d : ~hb_data_i;
        @(posedge ref_clk);
        hb_wr_n <= !wr;
        hb_rd_n <= wr;
        repeat (6) @(posedge ref_clk);
        hb_wr_n <= 1'b1;
        hb_rd_n <= 1'b1;
        // released data bus shows no stale copy
        hb_data_i <= ~hb_data_i;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule

/* File: bench/tb_top.sv */
// Purpose: self-checking bench of the host address decoder
// Assumes: 25 MHz clock, host model as bus partner
// Notes: register bus reads are checked by a monitor against a queue
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic vblank = 1'b0;
    logic [15:0] fb_rdata = 16'h0000;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [19:0] hb_addr;
    logic [15:0] hb_data_i, hb_data_o, fb_src, fb_mask;
    logic hb_wr_n, hb_rd_n, hb_data_oe, fb_rd_req, fb_wr_req, video_en, irq;
    logic [9:0] fb_x, fb_y;
    logic [7:0] fb_func;
    logic [4:0] fb_width;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [2:0] brd = 3'h0;
    int n_fail = 0, n_compared = 0, n_wr = 0;
    always #20 ref_clk = ~ref_clk;
    gxd_host_model u_host (.*);
    gxd_decoder u_dut (.*, .s_axi_wstrb(4'hf));
    // ==========================================
    // monitor: oldest note against each bus answer
    always @(posedge ref_clk) begin
        logic [33:0] er;
        logic [1:0] eb;
        if (rst_n && fb_wr_req) n_wr++;
        if (s_axi_rvalid && s_axi_rready) begin
            er = rq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, er)
        end
        if (s_axi_bvalid && s_axi_bready) begin
            eb = bq.pop_front();
            `CHK(s_axi_bresp, eb)
        end
    end
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // a wait that ran out counts as a mismatch
    task automatic tmo(input int n);
        if (n >= 100) begin
            n_fail++;
            finish_test();
        end
    endtask
    function automatic logic [33:0] ok(input logic [31:0] d);
        return {gxd_pkg::RESP_OKAY, d};
    endfunction
    // register write; address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        @(posedge ref_clk);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
        end while ((s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready) && n < 50);
        while (!s_axi_bvalid && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask
    // register read; expected answer noted first
    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        int n = 0;
        @(posedge ref_clk);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (!s_axi_arready && n < 50);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask
    // host access built from the address fields
    task automatic host(input logic wr, input logic upd, input logic [1:0] rs,
        input logic [1:0] sl, input logic ax, input logic [9:0] c, input logic [15:0] d);
        u_host.access(wr, {brd, upd, rs, sl, ax, c, 1'b0}, d);
    endtask
    // command load on slot 0, x axis
    task automatic cmd(input logic [9:0] c, input logic [15:0] d);
        host(1'b1, 1'b0, gxd_pkg::RSEL_CMD, 2'h0, 1'b0, c, d);
    endtask
    // ==========================================
    // main sequence
    initial begin
        logic [15:0] d, p;
        logic [9:0] co;
        logic [9:0] xs[4];
        int wr0;
        void'($urandom(94));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        axi_rd(gxd_pkg::OFS_FUNC, ok({24'h0, gxd_pkg::RST_FUNC}));
        axi_rd(gxd_pkg::OFS_WIDTH, ok({27'h0, gxd_pkg::RST_WIDTH}));
        axi_rd(8'h40, {gxd_pkg::RESP_SLVERR, 32'h0});
        axi_wr(8'h44, 32'h1, gxd_pkg::RESP_SLVERR);
        // every command code except clear, coordinate captured alongside
        for (int c = 0; c < 3; c++) begin
            d = 16'($urandom);
            co = {8'($urandom), c[1:0]};
            host(1'b1, 1'b0, gxd_pkg::RSEL_CMD, 2'h1, 1'b0, co, d);
            `CHK(fb_x, co)
            case (c)
                0: axi_rd(gxd_pkg::OFS_FUNC, ok({24'h0, d[7:0]}));
                1: axi_rd(gxd_pkg::OFS_WIDTH, ok({27'h0, d[4:0]}));
                default: axi_rd(gxd_pkg::OFS_CTRL, ok({16'h0, d}));
            endcase
        end
        `CHK(video_en, d[9])
        // another board select is ignored
        axi_wr(gxd_pkg::OFS_CFG, 32'h5, gxd_pkg::RESP_OKAY);
        brd = 3'h5;
        cmd(10'h0, 16'h003c);
        brd = 3'h0;
        cmd(10'h0, 16'h0033);
        brd = 3'h5;
        axi_rd(gxd_pkg::OFS_FUNC, ok(32'h3c));
        // four independent x slots, read back through y accesses
        for (int s = 0; s < 4; s++) begin
            xs[s] = 10'($urandom);
            host(1'b1, 1'b0, gxd_pkg::RSEL_NONE, s[1:0], 1'b0, xs[s], 16'hffff);
        end
        for (int s = 0; s < 4; s++) begin
            co = 10'($urandom);
            host(1'b0, 1'b0, gxd_pkg::RSEL_NONE, s[1:0], 1'b1, co, 16'h0);
            `CHK(fb_x, xs[s])
            `CHK(fb_y, co)
        end
        axi_rd(gxd_pkg::OFS_FUNC, ok(32'h3c));
        axi_rd(gxd_pkg::OFS_SRC, ok(32'h0));
        // source from data bus, update bit gates frame writes
        cmd(10'h1, 16'h0010);
        wr0 = n_wr;
        d = 16'($urandom);
        host(1'b1, 1'b0, gxd_pkg::RSEL_SRC, 2'h0, 1'b0, 10'h0, d);
        `CHK(fb_src, d)
        `CHK(n_wr, wr0)
        p = 16'($urandom);
        host(1'b1, 1'b1, gxd_pkg::RSEL_SRC, 2'h0, 1'b0, 10'h0, p);
        `CHK(n_wr, wr0 + 1)
        axi_rd(gxd_pkg::OFS_SRC, ok({16'h0, p}));
        // narrow width loads only the top mask bits
        cmd(10'h1, 16'h0004);
        d = 16'($urandom);
        host(1'b1, 1'b0, gxd_pkg::RSEL_MASK, 2'h0, 1'b0, 10'h0, d);
        `CHK(fb_mask, {d[15:12], 12'h0})
        cmd(10'h1, 16'h0010);
        // reads load from the frame buffer, latch one step behind
        d = 16'($urandom);
        fb_rdata <= d;
        host(1'b0, 1'b0, gxd_pkg::RSEL_SRC, 2'h0, 1'b0, 10'h0, 16'h0);
        `CHK(hb_data_o, p)
        `CHK(fb_src, d)
        fb_rdata <= ~d;
        host(1'b0, 1'b0, gxd_pkg::RSEL_SRC, 2'h0, 1'b0, 10'h0, 16'h0);
        `CHK(hb_data_o, d)
        host(1'b0, 1'b0, gxd_pkg::RSEL_MASK, 2'h0, 1'b0, 10'h0, 16'h0);
        `CHK(fb_mask, ~d)
        // interrupt: raise, mask, unmask, clear by command
        cmd(10'h2, 16'h0100);
        axi_wr(gxd_pkg::OFS_IRQ_EN, 32'h1, gxd_pkg::RESP_OKAY);
        axi_wr(gxd_pkg::OFS_IRQ_CLR, 32'h3, gxd_pkg::RESP_OKAY);
        axi_rd(gxd_pkg::OFS_IRQ_EN, ok(32'h1));
        vblank <= 1'b1;
        repeat (6) @(posedge ref_clk);
        vblank <= 1'b0;
        `CHK(irq, 1'b1)
        axi_rd(gxd_pkg::OFS_STATUS, ok(32'h1));
        axi_wr(gxd_pkg::OFS_IRQ_EN, 32'h0, gxd_pkg::RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        axi_wr(gxd_pkg::OFS_IRQ_EN, 32'h1, gxd_pkg::RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        cmd(10'h3, 16'h0);
        `CHK(irq, 1'b0)
        axi_rd(gxd_pkg::OFS_STATUS, ok(32'h2));
        finish_test();
    end
endmodule
